// >>> shared/dcps_pkg.sv
// Constants and types for the DC link pre-charge sequencer
package dcps_pkg;
	localparam int unsigned CLK_HZ = 50_000_000;
	// Times in milliseconds, as the sequence defines them
	localparam int unsigned OPEN_DELAY_MS = 1000;
	localparam int unsigned CHARGE_LIMIT_MS = 10000;
	localparam int unsigned OPEN_DELAY_CYC = OPEN_DELAY_MS * (CLK_HZ / 1000);
	localparam int unsigned CHARGE_LIMIT_CYC = CHARGE_LIMIT_MS * (CLK_HZ / 1000);
	// Steady-state settle count, in ticks
	localparam int unsigned STEADY_TICKS = 16;
	localparam int unsigned VOLT_W = 12;
	localparam int unsigned TRQ_W = 16;
	// Reset values
	localparam logic [VOLT_W-1:0] UVT_RST = 12'h000;
	localparam logic [VOLT_W-1:0] OVT_RST = 12'hfff;
	localparam logic [TRQ_W-1:0] TRQ_RST = 16'h0000;

	typedef enum logic [5:0] {
		DCPS_IDLE = 6'b000001,
		DCPS_WAIT_V = 6'b000010,
		DCPS_CLOSE = 6'b000100,
		DCPS_READY = 6'b001000,
		DCPS_DISABLE = 6'b010000,
		DCPS_FAULT = 6'b100000
	} dcps_state_e;
endpackage

// >>> verilog/dcps_derate.sv
// Torque limit derating against bus voltage, one direction
`timescale 1ns/1ns
`default_nettype none
module dcps_derate #(
	parameter int unsigned VOLT_W = 12,
	parameter int unsigned TRQ_W = 16,
	// 1: limit falls as voltage rises (regen), 0: as voltage falls (motoring)
	parameter bit RISING = 1'b1
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Inputs
	input wire logic active,
	input wire logic [VOLT_W-1:0] bus_volt,
	input wire logic [VOLT_W-1:0] knee,
	input wire logic [VOLT_W-1:0] limit_end,
	input wire logic [TRQ_W-1:0] limit_in,
	// Outputs
	output logic [TRQ_W-1:0] limit_out,
	output logic reducing
);
	initial
	begin
		if (VOLT_W < 2 || TRQ_W < 2 || VOLT_W > 16)
			$error("dcps_derate: unsupported width");
	end

	logic [VOLT_W-1:0] over;
	logic [VOLT_W-1:0] span;
	logic past_knee;
	logic past_end;
	logic [TRQ_W+VOLT_W-1:0] scaled;
	logic [TRQ_W-1:0] next_limit;

	// Linear ramp from full limit at the knee to zero at the end point
	always_comb
	begin
		past_knee = RISING ? (bus_volt >= knee) : (bus_volt <= knee);
		past_end = RISING ? (bus_volt >= limit_end) : (bus_volt <= limit_end);
		over = RISING ? VOLT_W'(bus_volt - knee) : VOLT_W'(knee - bus_volt);
		span = RISING ? VOLT_W'(limit_end - knee) : VOLT_W'(knee - limit_end);
		scaled = (TRQ_W+VOLT_W)'(limit_in) * (TRQ_W+VOLT_W)'(VOLT_W'(span - over));
		next_limit = limit_in;
		if (active && past_end)
			next_limit = '0;
		else if (active && past_knee && span != '0)
			next_limit = TRQ_W'(scaled / (TRQ_W+VOLT_W)'(span));
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			limit_out <= '0;
			reducing <= 1'b0;
		end
		else
		begin
			limit_out <= next_limit;
			reducing <= active && past_knee;
		end
	end
endmodule
`default_nettype wire

// >>> verilog/dcps_seq.sv
// DC link pre-charge sequencer top level
// Summary of operation
// - With pre-charge fitted, bank charges via resistors at power-up; contactor starts open.
// - Sequence starts on enable rising edge; enable set at power-up counts as edge.
// - State machine is held inhibited until configuration is valid.
// - Bridge test or control loop without enable raises interlock error and is refused.
// - After edge, wait for voltage above undervoltage threshold, then close contactor.
// - Ready only with enable, voltage at threshold, voltage steady, contactor confirmed. The code checks steadiness only on entry to ready, not while in ready.
// - Enable cleared: gate power off at once, contactor opens about one second later.
// - Uncommanded contactor closure while waiting for voltage sets charge fault and shuts the drive down.
// - Contactor state is taken from auxiliary contacts, not from the command.
// - Steady voltage and closure must occur within 10 s of edge, else fault.
// - If voltage recovers within 10 s, contactor recloses and operation resumes.
// - Three tunable thresholds: overvoltage, undervoltage and power loss.
// - Regenerating: regen limit derated from overvoltage threshold to zero at maximum.
// - Motoring: motoring limit derated from undervoltage threshold to zero at minimum.
// - Torque-limit warning set whenever either limit is being reduced.
// - Torque reference passes through unaltered by derating.
`timescale 1ns/1ns
`default_nettype none
module dcps_seq
	import dcps_pkg::*;
#(
	parameter int unsigned OPEN_DELAY = OPEN_DELAY_CYC,
	parameter int unsigned CHARGE_LIMIT = CHARGE_LIMIT_CYC,
	parameter int unsigned STEADY = STEADY_TICKS
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Software control
	input wire logic dc_link_enable_bit,
	input wire logic config_valid,
	input wire logic bridge_test_req,
	input wire logic control_loop_req,
	input wire logic precharge_fitted,
	// Tunable thresholds
	input wire logic [dcps_pkg::VOLT_W-1:0] undervoltage_threshold_value,
	input wire logic [dcps_pkg::VOLT_W-1:0] overvoltage_threshold_value,
	input wire logic [dcps_pkg::VOLT_W-1:0] power_loss_threshold_value,
	input wire logic [dcps_pkg::VOLT_W-1:0] overvoltage_max_value,
	input wire logic [dcps_pkg::VOLT_W-1:0] undervoltage_min_value,
	// Power stage feedback
	input wire logic [dcps_pkg::VOLT_W-1:0] bus_voltage,
	input wire logic contactor_aux_closed,
	input wire logic regenerating,
	// Torque
	input wire logic [dcps_pkg::TRQ_W-1:0] torque_reference_word,
	input wire logic [dcps_pkg::TRQ_W-1:0] regen_limit_set,
	input wire logic [dcps_pkg::TRQ_W-1:0] motor_limit_set,
	// Power stage commands
	output logic contactor_close,
	output logic gate_power_en,
	output logic bridge_test_run,
	output logic control_loop_run,
	// Status
	output logic link_ready,
	output logic link_interlock_error,
	output logic charge_fault_flag,
	output logic torque_limit_warning,
	output logic power_loss,
	output logic overvoltage,
	output logic [dcps_pkg::TRQ_W-1:0] torque_ref_out,
	output logic [dcps_pkg::TRQ_W-1:0] regen_limit,
	output logic [dcps_pkg::TRQ_W-1:0] motor_limit,
	output logic [2:0] seq_state
);
	initial
		if (OPEN_DELAY < 1 || CHARGE_LIMIT < 1 || STEADY < 1 || STEADY > 65535)
			$error("dcps_seq: unsupported timing parameter");

	dcps_state_e state;
	dcps_state_e next_state;
	logic en_q;
	logic open_seen;
	logic en_rise;
	logic [31:0] tmo_cnt;
	logic [31:0] dly_cnt;
	logic [15:0] steady_cnt;
	logic [dcps_pkg::VOLT_W-1:0] v_prev;
	logic v_ok;
	logic v_steady;
	logic tmo_hit;
	logic regen_red;
	logic motor_red;

	// Power-up counts a set enable as an edge because en_q resets low
	always_ff @(posedge core_clk or negedge rstn)
		if (!rstn)
			en_q <= 1'b0;
		else
			en_q <= dc_link_enable_bit;
	assign en_rise = dc_link_enable_bit && !en_q;

	// Closure counts as uncommanded from reset, and after a command only once the aux contacts were seen open
	always_ff @(posedge core_clk or negedge rstn)
		if (!rstn)
			open_seen <= 1'b1;
		else if (contactor_close || !contactor_aux_closed)
			open_seen <= !contactor_close;

	// Steady when the reading is at or above the undervoltage threshold and moves at most one code per cycle for STEADY cycles
	assign v_ok = bus_voltage >= undervoltage_threshold_value;
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			v_prev <= '0;
			steady_cnt <= '0;
		end
		else
		begin
			v_prev <= bus_voltage;
			if (!v_ok || (bus_voltage > v_prev + 1'b1) || (v_prev > bus_voltage + 1'b1))
				steady_cnt <= '0;
			else if (steady_cnt != 16'(STEADY))
				steady_cnt <= steady_cnt + 16'h0001;
		end
	end
	assign v_steady = steady_cnt == 16'(STEADY);

	// Charge window counter; restarted by each enable edge and each dip in ready
	assign tmo_hit = tmo_cnt >= CHARGE_LIMIT;
	always_ff @(posedge core_clk or negedge rstn)
		if (!rstn)
			tmo_cnt <= '0;
		else if (en_rise || state == DCPS_IDLE || state == DCPS_READY)
			tmo_cnt <= '0;
		else if (!tmo_hit)
			tmo_cnt <= tmo_cnt + 32'h1;

	always_ff @(posedge core_clk or negedge rstn)
		if (!rstn)
			dly_cnt <= '0;
		else
			dly_cnt <= (state == DCPS_DISABLE) ? dly_cnt + 32'h1 : '0;

	// Sequence; a disabled config holds it in idle so no edge is acted on early
	always_comb
	begin
		next_state = state;
		case (state)
			DCPS_IDLE:
				if (config_valid && dc_link_enable_bit && precharge_fitted)
					next_state = DCPS_WAIT_V;
			DCPS_WAIT_V:
				if (!dc_link_enable_bit)
					next_state = DCPS_DISABLE;
				else if (tmo_hit)
					next_state = DCPS_FAULT;
				else if (v_ok)
					next_state = DCPS_CLOSE;
			DCPS_CLOSE:
				if (!dc_link_enable_bit)
					next_state = DCPS_DISABLE;
				else if (tmo_hit)
					next_state = DCPS_FAULT;
				else if (v_steady && contactor_aux_closed)
					next_state = DCPS_READY;
			DCPS_READY:
				if (!dc_link_enable_bit)
					next_state = DCPS_DISABLE;
				else if (!v_ok || !contactor_aux_closed)
					next_state = DCPS_WAIT_V;
			DCPS_DISABLE:
				if (dly_cnt >= OPEN_DELAY - 1)
					next_state = DCPS_IDLE;
			DCPS_FAULT:
				if (!dc_link_enable_bit)
					next_state = DCPS_IDLE;
			default:
				next_state = DCPS_IDLE;
		endcase
		if (state != DCPS_FAULT && state != DCPS_IDLE && !contactor_close && open_seen
			&& contactor_aux_closed && state != DCPS_DISABLE)
			next_state = DCPS_FAULT;
		if (!config_valid)
			next_state = DCPS_IDLE;
	end

	always_ff @(posedge core_clk or negedge rstn)
		if (!rstn)
			state <= DCPS_IDLE;
		else
			state <= next_state;

	// Contactor opens at reset so charging goes through the resistors
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			contactor_close <= 1'b0;
			gate_power_en <= 1'b0;
			link_ready <= 1'b0;
			seq_state <= 3'h0;
		end
		else
		begin
			contactor_close <= next_state == DCPS_CLOSE || next_state == DCPS_READY
				|| (next_state == DCPS_DISABLE && contactor_close);
			gate_power_en <= next_state == DCPS_READY && dc_link_enable_bit;
			link_ready <= next_state == DCPS_READY && dc_link_enable_bit;
			case (next_state)
				DCPS_WAIT_V: seq_state <= 3'h1;
				DCPS_CLOSE: seq_state <= 3'h2;
				DCPS_READY: seq_state <= 3'h3;
				DCPS_DISABLE: seq_state <= 3'h4;
				DCPS_FAULT: seq_state <= 3'h5;
				default: seq_state <= 3'h0;
			endcase
		end
	end

	// Fault latch: set wins over the clear by a new enable rising edge
	always_ff @(posedge core_clk or negedge rstn)
		if (!rstn)
			charge_fault_flag <= 1'b0;
		else if (next_state == DCPS_FAULT)
			charge_fault_flag <= 1'b1;
		else if (en_rise)
			charge_fault_flag <= 1'b0;

	// Interlock is sticky until the requests are withdrawn
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			link_interlock_error <= 1'b0;
			bridge_test_run <= 1'b0;
			control_loop_run <= 1'b0;
		end
		else
		begin
			if ((bridge_test_req || control_loop_req) && !dc_link_enable_bit)
				link_interlock_error <= 1'b1;
			else if (!bridge_test_req && !control_loop_req)
				link_interlock_error <= 1'b0;
			bridge_test_run <= bridge_test_req && dc_link_enable_bit
				&& !link_interlock_error && next_state == DCPS_READY;
			control_loop_run <= control_loop_req && dc_link_enable_bit
				&& !link_interlock_error && next_state == DCPS_READY;
		end
	end

	// Threshold monitors
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			power_loss <= 1'b0;
			overvoltage <= 1'b0;
			torque_ref_out <= TRQ_RST;
			torque_limit_warning <= 1'b0;
		end
		else
		begin
			power_loss <= bus_voltage <= power_loss_threshold_value;
			overvoltage <= bus_voltage >= overvoltage_threshold_value;
			torque_ref_out <= torque_reference_word;
			torque_limit_warning <= regen_red || motor_red;
		end
	end

	dcps_derate #(
		.VOLT_W(VOLT_W),
		.TRQ_W(TRQ_W),
		.RISING(1'b1)
	) u_regen (
		.core_clk(core_clk),
		.rstn(rstn),
		.active(regenerating),
		.bus_volt(bus_voltage),
		.knee(overvoltage_threshold_value),
		.limit_end(overvoltage_max_value),
		.limit_in(regen_limit_set),
		.limit_out(regen_limit),
		.reducing(regen_red)
	);
	dcps_derate #(
		.VOLT_W(VOLT_W),
		.TRQ_W(TRQ_W),
		.RISING(1'b0)
	) u_motor (
		.core_clk(core_clk),
		.rstn(rstn),
		.active(!regenerating),
		.bus_volt(bus_voltage),
		.knee(undervoltage_threshold_value),
		.limit_end(undervoltage_min_value),
		.limit_in(motor_limit_set),
		.limit_out(motor_limit),
		.reducing(motor_red)
	);

	// Checks
	sequence en_drop_s;
		$fell(dc_link_enable_bit);
	endsequence
	sequence gate_off_s;
		##1 !gate_power_en;
	endsequence

	gate_cut_a: assert property (@(posedge core_clk) disable iff (!rstn)
		en_drop_s |-> gate_off_s) else $error("gates stay powered after enable drop");
	ready_cond_a: assert property (@(posedge core_clk) disable iff (!rstn)
		link_ready |-> contactor_close && $past(contactor_aux_closed))
		else $error("ready without closed contactor");
	interlock_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(bridge_test_req && !dc_link_enable_bit) |=> link_interlock_error && !bridge_test_run)
		else $error("bridge test without enable not refused");
	inhibit_a: assert property (@(posedge core_clk) disable iff (!rstn)
		!config_valid |=> state == DCPS_IDLE) else $error("sequencer ran without config");
	uncmd_close_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(state == DCPS_WAIT_V && contactor_aux_closed && !contactor_close && open_seen
		&& config_valid) |=> charge_fault_flag)
		else $error("uncommanded closure not flagged");
	timeout_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(tmo_hit && state inside {DCPS_WAIT_V, DCPS_CLOSE} && dc_link_enable_bit
		&& config_valid) |=> charge_fault_flag && !contactor_close)
		else $error("charge timeout not faulted");
	close_after_v_a: assert property (@(posedge core_clk) disable iff (!rstn)
		$rose(contactor_close) |-> $past(v_ok)) else $error("contactor closed below threshold");
	warn_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(regen_red || motor_red) |=> torque_limit_warning) else $error("warning missing");
	trq_pass_a: assert property (@(posedge core_clk) disable iff (!rstn)
		$past(rstn) |-> torque_ref_out == $past(torque_reference_word))
		else $error("reference altered");
	open_delay_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(state == DCPS_DISABLE && dly_cnt < OPEN_DELAY - 1 && config_valid) |=> contactor_close)
		else $error("contactor opened early");
endmodule
`default_nettype wire

// >>> verification/dcps_contactor_model.sv
// Pre-charge contactor with its auxiliary contacts, as seen by the sequencer
`timescale 1ns/1ns
`default_nettype none
module dcps_contactor_model #(
	parameter int unsigned LAG = 3
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Coil command and welded-contact injection
	input wire logic coil,
	input wire logic weld,
	// Auxiliary contact
	output logic aux_closed
);
	int unsigned cnt;
	// Contacts follow the coil only after armature travel, so ready cannot ride on the command
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cnt <= 0;
			aux_closed <= 1'b0;
		end
		else if (weld)
			aux_closed <= 1'b1;
		else if (coil == aux_closed)
			cnt <= 0;
		else if (cnt + 1 >= LAG)
		begin
			aux_closed <= coil;
			cnt <= 0;
		end
		else
			cnt <= cnt + 1;
	end
endmodule
`default_nettype wire

// >>> verification/dc_bus_precharge_sequencer_bench.sv
// Self-checking bench for the DC link pre-charge sequencer
`timescale 1ns/1ns
`default_nettype none
module dc_bus_precharge_sequencer_bench;
	import dcps_pkg::*;
	localparam int unsigned CLIM = 200;
	typedef struct packed {
		logic regen;
		logic [VOLT_W-1:0] volt;
		logic [TRQ_W-1:0] lim;
		logic [TRQ_W-1:0] tref;
		logic [TRQ_W-1:0] exp_lim;
		logic warn;
		logic pwr_loss;
		logic over_v;
	} dcps_row_s;
	// Points well clear of the knees, since the slope between them is a design choice
	dcps_row_s rows [4] = '{
		'{1'b1, 12'h800, 16'h1000, 16'h1234, 16'h1000, 1'b0, 1'b0, 1'b0},
		'{1'b1, 12'hf00, 16'h1000, 16'h5678, 16'h0000, 1'b1, 1'b0, 1'b1},
		'{1'b0, 12'h800, 16'h0800, 16'h9abc, 16'h0800, 1'b0, 1'b0, 1'b0},
		'{1'b0, 12'h100, 16'h0800, 16'hdef0, 16'h0000, 1'b1, 1'b1, 1'b0}};
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic en = 1'b0;
	logic cfg = 1'b1;
	logic pf = 1'b1;
	logic bt_req = 1'b0;
	logic cl_req = 1'b0;
	logic regen = 1'b0;
	logic weld = 1'b0;
	logic [VOLT_W-1:0] volt = 12'h100;
	logic [TRQ_W-1:0] lim = 16'h0000;
	logic [TRQ_W-1:0] tref = 16'h0000;
	logic contactor_close, gate_power_en, bridge_test_run, control_loop_run, aux;
	logic link_ready, link_interlock_error, charge_fault_flag, torque_limit_warning;
	logic [TRQ_W-1:0] torque_ref_out, regen_limit, motor_limit;
	logic [2:0] seq_state;
	logic power_loss, overvoltage;
	int failures = 0;
	int comparisons = 0;
	int ticks = 0;
	always #10 core_clk = ~core_clk;
	dcps_seq #(.OPEN_DELAY(20), .CHARGE_LIMIT(CLIM), .STEADY(4)) dut_u (
		.core_clk(core_clk), .rstn(rstn), .dc_link_enable_bit(en), .config_valid(cfg),
		.bridge_test_req(bt_req), .control_loop_req(cl_req), .precharge_fitted(pf),
		.undervoltage_threshold_value(12'h400), .overvoltage_threshold_value(12'hc00),
		.power_loss_threshold_value(12'h300), .overvoltage_max_value(12'he00),
		.undervoltage_min_value(12'h200), .bus_voltage(volt), .contactor_aux_closed(aux),
		.regenerating(regen), .torque_reference_word(tref), .regen_limit_set(lim),
		.motor_limit_set(lim), .contactor_close(contactor_close),
		.gate_power_en(gate_power_en), .bridge_test_run(bridge_test_run),
		.control_loop_run(control_loop_run), .link_ready(link_ready),
		.link_interlock_error(link_interlock_error), .charge_fault_flag(charge_fault_flag),
		.torque_limit_warning(torque_limit_warning), .power_loss(power_loss),
		.overvoltage(overvoltage),
		.torque_ref_out(torque_ref_out), .regen_limit(regen_limit),
		.motor_limit(motor_limit), .seq_state(seq_state));
	dcps_contactor_model contactor_u (.core_clk(core_clk), .rstn(rstn),
		.coil(contactor_close), .weld(weld), .aux_closed(aux));
	task automatic stop_test;
		$display("Counts: comparisons=%0d failures=%0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge core_clk)
	begin
		ticks++;
		if (ticks == 5000)
		begin
			failures++;
			stop_test();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	function automatic logic pick(input int s);
		case (s)
			0: return contactor_close;
			1: return link_ready;
			default: return charge_fault_flag;
		endcase
	endfunction
	// Bounded wait, so a stuck sequencer shows as a mismatch and not a hang
	task automatic wt(input int s, input logic v, input int n);
		int i;
		i = 0;
		while (pick(s) !== v && i < n)
		begin
			@(negedge core_clk);
			i++;
		end
		chk(pick(s), v);
	endtask
	task automatic do_reset;
		rstn = 1'b0;
		cyc(10);
		rstn = 1'b1;
		cyc(2);
	endtask
	initial
	begin
		cyc(1);
		do_reset();
		chk(seq_state, 3'd0);
		chk(contactor_close, 1'b0);
		foreach (rows[i])
		begin
			regen = rows[i].regen;
			volt = rows[i].volt;
			lim = rows[i].lim;
			tref = rows[i].tref;
			cyc(4);
			chk(torque_ref_out, rows[i].tref);
			chk(rows[i].regen ? regen_limit : motor_limit, rows[i].exp_lim);
			chk(torque_limit_warning, rows[i].warn);
			chk({power_loss, overvoltage}, {rows[i].pwr_loss, rows[i].over_v});
		end
		$display("Test derating done");
		for (int i = 0; i < 2; i++)
		begin
			bt_req = (i == 0);
			cl_req = (i == 1);
			cyc(3);
			chk(link_interlock_error, 1'b1);
			chk({bridge_test_run, control_loop_run}, 2'b00);
			bt_req = 1'b0;
			cl_req = 1'b0;
			cyc(3);
			chk(link_interlock_error, 1'b0);
		end
		$display("Test interlock done");
		for (int i = 0; i < 2; i++)
		begin
			cfg = (i == 1);
			pf = (i == 0);
			en = 1'b1;
			cyc(10);
			chk(seq_state, 3'd0);
			chk(contactor_close, 1'b0);
			en = 1'b0;
			cfg = 1'b1;
			pf = 1'b1;
			cyc(2);
		end
		$display("Test inhibit done");
		volt = 12'h100;
		en = 1'b1;
		cyc(5);
		chk(seq_state, 3'd1);
		chk(contactor_close, 1'b0);
		volt = 12'h800;
		wt(0, 1'b1, 10);
		chk(link_ready, 1'b0);
		wt(1, 1'b1, 20);
		chk(gate_power_en, 1'b1);
		cl_req = 1'b1;
		bt_req = 1'b1;
		cyc(3);
		chk({bridge_test_run, control_loop_run}, 2'b11);
		volt = 12'h100;
		wt(1, 1'b0, 10);
		volt = 12'h800;
		wt(1, 1'b1, 40);
		en = 1'b0;
		cyc(2);
		chk(gate_power_en, 1'b0);
		chk(contactor_close, 1'b1);
		cyc(10);
		chk(contactor_close, 1'b1);
		wt(0, 1'b0, 30);
		cl_req = 1'b0;
		bt_req = 1'b0;
		$display("Test sequence done");
		cyc(5);
		volt = 12'h100;
		en = 1'b1;
		cyc(3);
		weld = 1'b1;
		wt(2, 1'b1, 10);
		chk(contactor_close, 1'b0);
		weld = 1'b0;
		en = 1'b0;
		cyc(8);
		en = 1'b1;
		cyc(CLIM - 20);
		chk(charge_fault_flag, 1'b0);
		wt(2, 1'b1, 40);
		chk(contactor_close, 1'b0);
		chk(seq_state, 3'd5);
		$display("Test faults done");
		volt = 12'h800;
		do_reset();
		wt(0, 1'b1, 30);
		$display("Test power-up enable done");
		stop_test();
	end
endmodule
`default_nettype wire
